// ---- logic/pcrr_clkdiv.sv ----
// Programmable divider: output period is divide input ticks
module pcrr_clkdiv (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Input rate and ratio
    input wire logic tickIn,
    input wire logic [4:0] divide,
    // Divided clock
    output logic clkOut,
    output logic tickOut
);

    pcrr_pkg::pcrr_div_s r;
    pcrr_pkg::pcrr_div_s n;

    always_comb
    begin
        n = r;
        n.tick = 1'b0;
        if (tickIn)
        begin
            // Wrap also covers a ratio lowered mid-period
            if (r.count >= divide - 5'h01)
            begin
                n.count = 5'h00;
                n.tick = 1'b1;
            end
            else
            begin
                n.count = r.count + 5'h01;
            end
            n.clk = (n.count < (divide >> 1));
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign clkOut = r.clk;
    assign tickOut = r.tick;

endmodule // pcrr_clkdiv

// ---- logic/pcrr_pkg.sv ----
// Types shared by the clock and reset block
package pcrr_pkg;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_REF,
        ST_CORE,
        ST_RUN
    } pcrr_state_e;

    typedef struct packed {
        pcrr_state_e state;
        logic [12:0] count;
        logic refPrev;
        logic coreResetN;
        logic [6:0] mult;
        logic [1:0] divSel;
        logic [4:0] divVal;
        logic inHalf;
        logic [1:0] sdrSel;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pcrr_top_s;

    typedef struct packed {
        logic [4:0] count;
        logic clk;
        logic tick;
    } pcrr_div_s;

endpackage

// ---- logic/pcrr_regs.svh ----
// Register map, field layout, reset values and timing counts of the clock and reset block
//
// What this block does
// - The oscillator runs at two times the multiplier times the PLL input, and the core clock is that divided by the post divider.
// - The post divider is 2, 4, 8 or 16 from its setting in the control register, and is 2 while reset is active.
// - The PLL input is the reference clock, or the reference clock halved when the input divider is on.
// - During reset the multiplier is loaded from the two clock-ratio straps, and software may reprogram it afterwards.
// - The peripheral clock period is exactly twice the core clock period and times all peripherals.
// - The SDRAM clock period is the core clock period times the programmed SDRAM clock ratio.
// - After the reset pin rises the core stays in reset for 4096 reference cycles plus 2 core cycles.
// - A missed setup of the reset release against the reference clock may add one reference cycle, to 4097 at most.
// - Internal memory, core and serial ports run from the PLL core clock, a multiple of the reference clock.
`ifndef PCRR_REGS_SVH
`define PCRR_REGS_SVH

`define PCRR_ADDR_W 12
`define PCRR_CTRL_ADDR 12'h000
`define PCRR_STATUS_ADDR 12'h004

`define PCRR_MULT_LSB 0
`define PCRR_MULT_MSB 6
`define PCRR_DIV_LSB 7
`define PCRR_DIV_MSB 8
`define PCRR_INHALF_BIT 9
`define PCRR_SDR_LSB 10
`define PCRR_SDR_MSB 11

`define PCRR_ST_CORERST_BIT 0
`define PCRR_ST_STRAP_LSB 1
`define PCRR_ST_STRAP_MSB 2
`define PCRR_ST_DIVVAL_LSB 3
`define PCRR_ST_DIVVAL_MSB 7

`define PCRR_DIV_RESET 2'h0
`define PCRR_SDR_RESET 2'h0
`define PCRR_SDR_BASE 5'h02
`define PCRR_POSTDIV_BASE 5'h02

`define PCRR_STRAP_MULT0 7'h20
`define PCRR_STRAP_MULT1 7'h10
`define PCRR_STRAP_MULT2 7'h08
`define PCRR_STRAP_MULT3 7'h04

`define PCRR_REF_CYCLES 4096
`define PCRR_CORE_CYCLES 3'h2
`define PCRR_PCLK_RATIO 5'h02

`endif

// ---- logic/pcrr_top.sv ----
// Core clock dividers, PLL settings and core reset release
`include "pcrr_regs.svh"

module pcrr_top #(
    parameter int REF_CYCLES = `PCRR_REF_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Board side
    input wire logic resetPinN,
    input wire logic referenceClockInput,
    input wire logic [1:0] clockRatioStrapPins,
    // Reset to the core
    output logic coreResetN,
    // Generated clocks
    output logic coreClock,
    output logic coreClockTick,
    output logic peripheralClock,
    output logic sdramClock,
    // Settings to the analog PLL
    output logic [6:0] pllMultiplier,
    output logic inputDividerEnable,
    output logic [4:0] pllPostDivider
);

    // First sampled edge opens the count, so full reference periods follow it
    localparam logic [12:0] REF_LAST = 13'(REF_CYCLES);

    pcrr_pkg::pcrr_top_s r;
    pcrr_pkg::pcrr_top_s n;

    logic [4:0] postDivVal;
    logic [4:0] sdrVal;
    logic [6:0] strapMult;
    logic refRise;
    logic coreTick;

    // Post divider of 2, 4, 8 or 16
    assign postDivVal = r.divVal;
    assign sdrVal = `PCRR_SDR_BASE + {3'h0, r.sdrSel};
    // Input is synchronous, so one flop of history gives the edge
    assign refRise = referenceClockInput & ~r.refPrev;

    always_comb
    begin
        case (clockRatioStrapPins)
            2'h0: strapMult = `PCRR_STRAP_MULT0;
            2'h1: strapMult = `PCRR_STRAP_MULT1;
            2'h2: strapMult = `PCRR_STRAP_MULT2;
            default: strapMult = `PCRR_STRAP_MULT3;
        endcase
    end

    always_comb
    begin
        n = r;
        n.refPrev = referenceClockInput;

        // No wait state: answer in the first access cycle
        n.pready = psel & ~penable;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (psel && !penable)
        begin
            case (paddr)
                `PCRR_CTRL_ADDR:
                begin
                    n.prdata[`PCRR_MULT_MSB:`PCRR_MULT_LSB] = r.mult;
                    n.prdata[`PCRR_DIV_MSB:`PCRR_DIV_LSB] = r.divSel;
                    n.prdata[`PCRR_INHALF_BIT] = r.inHalf;
                    n.prdata[`PCRR_SDR_MSB:`PCRR_SDR_LSB] = r.sdrSel;
                end
                `PCRR_STATUS_ADDR:
                begin
                    n.prdata[`PCRR_ST_CORERST_BIT] = r.coreResetN;
                    n.prdata[`PCRR_ST_STRAP_MSB:`PCRR_ST_STRAP_LSB] = clockRatioStrapPins;
                    n.prdata[`PCRR_ST_DIVVAL_MSB:`PCRR_ST_DIVVAL_LSB] = postDivVal;
                end
                default: n.pslverr = 1'b1;
            endcase
        end

        // Software write, honoured only outside board reset
        if (psel && penable && r.pready && pwrite && paddr == `PCRR_CTRL_ADDR && resetPinN)
        begin
            n.mult = pwdata[`PCRR_MULT_MSB:`PCRR_MULT_LSB];
            n.divSel = pwdata[`PCRR_DIV_MSB:`PCRR_DIV_LSB];
            n.inHalf = pwdata[`PCRR_INHALF_BIT];
            n.sdrSel = pwdata[`PCRR_SDR_MSB:`PCRR_SDR_LSB];
        end

        case (r.state)
            pcrr_pkg::ST_HOLD:
            begin
                if (resetPinN)
                begin
                    n.state = pcrr_pkg::ST_REF;
                    n.count = '0;
                end
            end
            pcrr_pkg::ST_REF:
            begin
                // Reference edges counted only once the pin is sampled high
                if (refRise)
                begin
                    if (r.count == REF_LAST)
                    begin
                        n.state = pcrr_pkg::ST_CORE;
                        n.count = '0;
                    end
                    else
                    begin
                        n.count = r.count + 13'h0001;
                    end
                end
            end
            pcrr_pkg::ST_CORE:
            begin
                if (coreTick)
                begin
                    if (r.count[2:0] == `PCRR_CORE_CYCLES - 3'h1)
                    begin
                        n.state = pcrr_pkg::ST_RUN;
                        n.coreResetN = 1'b1;
                    end
                    else
                    begin
                        n.count = r.count + 13'h0001;
                    end
                end
            end
            pcrr_pkg::ST_RUN:
            begin
                n.coreResetN = 1'b1;
            end
            default:
            begin
                n.state = pcrr_pkg::ST_HOLD;
            end
        endcase

        // Board reset overrides state, count, core reset and control fields and reloads defaults
        if (!resetPinN)
        begin
            n.state = pcrr_pkg::ST_HOLD;
            n.count = '0;
            n.coreResetN = 1'b0;
            n.mult = strapMult;
            n.divSel = `PCRR_DIV_RESET;
            n.inHalf = 1'b0;
            n.sdrSel = `PCRR_SDR_RESET;
        end

        // Divider value kept in a flop so the port is registered
        n.divVal = `PCRR_POSTDIV_BASE << n.divSel;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.state <= pcrr_pkg::ST_HOLD;
            r.mult <= `PCRR_STRAP_MULT0;
            r.divSel <= `PCRR_DIV_RESET;
            r.divVal <= `PCRR_POSTDIV_BASE;
            r.sdrSel <= `PCRR_SDR_RESET;
        end
        else
        begin
            r <= n;
        end
    end

    // Core clock: oscillator divided by the post divider
    pcrr_clkdiv u_core_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .tickIn(1'b1),
        .divide(postDivVal),
        .clkOut(coreClock),
        .tickOut(coreTick)
    );

    // Peripheral clock at half the core clock
    pcrr_clkdiv u_pclk_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .tickIn(coreTick),
        .divide(`PCRR_PCLK_RATIO),
        .clkOut(peripheralClock),
        .tickOut()
    );

    // SDRAM clock at the programmed ratio
    pcrr_clkdiv u_sdram_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .tickIn(coreTick),
        .divide(sdrVal),
        .clkOut(sdramClock),
        .tickOut()
    );

    assign coreClockTick = coreTick;
    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign coreResetN = r.coreResetN;
    assign pllMultiplier = r.mult;
    assign inputDividerEnable = r.inHalf;
    assign pllPostDivider = r.divVal;

endmodule // pcrr_top

// ---- sim/pcrr_board_model.sv ----
// Board model: free-running reference clock, reset pin and clock-ratio straps
module pcrr_board_model #(
    parameter int SETTLE_REF = 8
) (
    // Clock
    input wire logic mclk,
    // Board pins
    output logic referenceClockInput,
    output logic resetPinN,
    output logic [1:0] clockRatioStrapPins
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        resetPinN = 1'b0;
        clockRatioStrapPins = 2'h0;
    end
    // Runs free, changed just after mclk edges, six mclk periods a cycle
    initial
    begin
        referenceClockInput = 1'b0;
        forever
        begin
            repeat (3) @(posedge mclk);
            referenceClockInput <= ~referenceClockInput;
        end
    end
    task automatic pulse_reset(input logic [1:0] s);
        @(posedge mclk) resetPinN <= 1'b0;
        clockRatioStrapPins <= s;
        repeat (SETTLE_REF) @(posedge referenceClockInput);
        @(posedge mclk) resetPinN <= 1'b1;
    endtask
endmodule // pcrr_board_model

// ---- sim/pcrr_top_sva.sv ----
// Checker on the ports of the clock and reset block
module pcrr_top_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB
    input wire logic penable,
    input wire logic pready,
    // Board side and outputs
    input wire logic resetPinN,
    input wire logic [1:0] clockRatioStrapPins,
    input wire logic coreResetN,
    input wire logic coreClockTick,
    input wire logic [6:0] pllMultiplier,
    input wire logic inputDividerEnable,
    input wire logic [4:0] pllPostDivider
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] gap_reg;
    logic armed_reg;
    // Cycles since the last core tick, armed from the first tick seen on a steady divider
    always_ff @(posedge mclk)
    begin
        gap_reg <= (!rst_n || coreClockTick) ? 8'h01 : gap_reg + 8'h01;
        armed_reg <= rst_n && $stable(pllPostDivider) && (armed_reg || coreClockTick);
    end
    property p_div_set; pllPostDivider inside {5'h02, 5'h04, 5'h08, 5'h10}; endproperty
    a_div_set: assert property (p_div_set) else $error("divider off set");
    property p_div_hold; !resetPinN |=> pllPostDivider == 5'h02; endproperty
    a_div_hold: assert property (p_div_hold) else $error("divider not 2");
    property p_input_divider_enable_hold; !resetPinN |=> !inputDividerEnable; endproperty
    a_input_divider_enable_hold: assert property (p_input_divider_enable_hold) else $error("input divider on");
    property p_mult_strap; !resetPinN |=> pllMultiplier == 7'h20 >> $past(clockRatioStrapPins); endproperty
    a_mult_strap: assert property (p_mult_strap) else $error("multiplier not strap");
    property p_core_hold; !resetPinN |=> !coreResetN; endproperty
    a_core_hold: assert property (p_core_hold) else $error("core out of reset");
    property p_core_free; $rose(coreResetN) |-> $past(coreClockTick) && $past(resetPinN); endproperty
    a_core_free: assert property (p_core_free) else $error("core release off tick");
    property p_core_period;
        coreClockTick && armed_reg && $stable(pllPostDivider) |-> gap_reg == 8'(pllPostDivider);
    endproperty
    a_core_period: assert property (p_core_period) else $error("core period wrong");
    property p_ready_once; pready |-> penable && !$past(penable); endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready out of place");
endmodule // pcrr_top_sva

bind pcrr_top pcrr_top_sva i_pcrr_top_sva (.mclk, .rst_n, .penable, .pready, .resetPinN,
    .clockRatioStrapPins, .coreResetN, .coreClockTick, .pllMultiplier, .inputDividerEnable,
    .pllPostDivider);

// ---- sim/tb_pcrr_top.sv ----
// Testbench for the clock and reset block
module tb_pcrr_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, resetPinN, referenceClockInput, coreResetN, coreClock, coreClockTick;
    logic peripheralClock, sdramClock, inputDividerEnable, er;
    logic [31:0] prdata, rd;
    logic [1:0] clockRatioStrapPins;
    logic [6:0] pllMultiplier;
    logic [4:0] pllPostDivider;
    int failures = 0;
    int comparisons = 0;
    always #5 mclk = ~mclk;
    pcrr_top #(.REF_CYCLES(8)) i_pcrr_top (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .resetPinN, .referenceClockInput,
        .clockRatioStrapPins, .coreResetN, .coreClock, .coreClockTick, .peripheralClock,
        .sdramClock, .pllMultiplier, .inputDividerEnable, .pllPostDivider);
    pcrr_board_model i_pcrr_board_model (.mclk, .referenceClockInput, .resetPinN,
        .clockRatioStrapPins);
    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        @(posedge mclk);
        // Pready, read data and error taken at the rising edge that ends the access
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50)
        begin
            failures++;
            complete_run();
        end
    endtask
    // Mclk cycles between two rises of a generated clock
    task automatic per(input int k, input int exp);
        logic p, v;
        int c, s;
        p = 1'b1;
        c = 0;
        s = 0;
        while (s < 2 && c < 400)
        begin
            @(negedge mclk);
            v = k == 0 ? coreClock : (k == 1 ? peripheralClock : sdramClock);
            if (v === 1'b1 && p === 1'b0)
                s++;
            c = (s == 1 && v === 1'b1 && p === 1'b0) ? 1 : c + 1;
            p = v;
        end
        chk(32'(c - 1), 32'(exp));
        if (s < 2)
            complete_run();
    endtask
    initial
    begin
        logic [31:0] v;
        int c;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            i_pcrr_board_model.pulse_reset(2'(s));
            for (c = 0; c < 200 && coreResetN !== 1'b1; c++)
                @(negedge mclk);
            // Eight or nine reference periods of six cycles, then two core periods of two
            chk(32'(c >= 54 && c <= 64), 32'h1);
            if (c == 200)
                complete_run();
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, 32'(7'h20 >> s));
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, 32'h11 | 32'(s << 1));
        end
        for (int k = 0; k < 4; k++)
        begin
            v = 32'(k << 10 | 1 << 9 | k << 7 | 'h11);
            apb(1'b1, 12'h000, v);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, v);
            chk(32'({pllMultiplier, inputDividerEnable, pllPostDivider}), 32'({7'h11, 1'b1, 5'(2 << k)}));
            repeat (200) @(posedge mclk);
            per(0, 2 << k);
            per(1, 4 << k);
            per(2, (2 + k) * (2 << k));
        end
        apb(1'b1, 12'h008, 32'hffffffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd | 32'(!er), 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h87);
        apb(1'b1, 12'h000, 32'h00000008);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000008);
        chk(32'({pllMultiplier, inputDividerEnable, pllPostDivider}), 32'({7'h08, 1'b0, 5'h02}));
        complete_run();
    end
endmodule // tb_pcrr_top
